// *** aim_pkg.sv ***
// Package for the analog input speed mixer: register map, fields, types
package aim_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;    // Mode, mixing, switch roles, options
    localparam logic [7:0] OFF_CAL1 = 8'h04;    // Throttle channel calibration
    localparam logic [7:0] OFF_CAL2 = 8'h08;    // Steering channel calibration
    localparam logic [7:0] OFF_RAW = 8'h0c;     // Latest raw samples
    localparam logic [7:0] OFF_SPEED = 8'h10;   // Speed command and switch state
    localparam logic [7:0] OFF_STAT = 8'h14;    // Sticky event flags
    localparam logic [7:0] OFF_MASK = 8'h18;    // Interrupt mask

    // Control field positions
    localparam int CTRL_ANALOG = 0;
    localparam int CTRL_MIX_LO = 1;
    localparam int CTRL_SW1_LO = 3;
    localparam int CTRL_SW2_LO = 5;
    localparam int CTRL_IGN_DISC = 7;
    localparam int CTRL_PULLUP1 = 8;
    localparam int CTRL_PULLUP2 = 9;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Calibration packs neutral [11:0] and forward extreme [27:16]; reverse implied
    localparam logic [31:0] CAL_RST = 32'h0fff_0800;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;

    // Sample width and limits
    localparam int SAMPLE_W = 12;
    localparam logic [11:0] DISC_LOW = 12'h010;   // Near ground rail
    localparam logic [11:0] DISC_HIGH = 12'hff0;  // Near supply rail
    localparam logic signed [12:0] SPEED_MAX = 13'sh0c80;  // Full forward, 3200
    localparam int STAT_W = 4;

    // Mixing modes
    typedef enum logic [1:0]
    {
        AIM_MIX_OFF = 2'h0,
        AIM_MIX_LEFT = 2'h1,
        AIM_MIX_RIGHT = 2'h2
    } aim_mix_t;

    // Switch roles for a channel not used for speed
    typedef enum logic [1:0]
    {
        AIM_SW_NONE = 2'h0,
        AIM_SW_LIMIT_FWD = 2'h1,
        AIM_SW_LIMIT_REV = 2'h2,
        AIM_SW_KILL = 2'h3
    } aim_sw_t;

    // Calibration pair for one channel
    typedef struct packed
    {
        logic [11:0] forward;
        logic [11:0] neutral;
    } aim_cal_t;

    // Sample pair from the converter
    typedef struct packed
    {
        logic [11:0] ch2;
        logic [11:0] ch1;
    } aim_samples_t;

endpackage : aim_pkg

// *** aim_speed_mixer.sv ***
// Analog input speed mixer with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - Samples always captured and readable by software
// - Each channel held as 12-bit code
// - Analog mode derives speed from calibration, mixing
// - Forward extreme max, neutral zero, opposite reverse
// - Mixing off uses throttle channel only
// - Mixing uses throttle plus steering channels
// - Left mixing sums throttle and steering
// - Right mixing subtracts steering from throttle
// - Unused channel may be limit or kill
// - Switch active above half forward value
// - Active kill stops motor, active limit only in its own direction
// - Rail-level sample flags channel disconnected
// - Broken switch wiring gives error or active
// - Option disables disconnection detection
// - Pull-up per channel, switch two states
module aim_speed_mixer #(
    parameter int SPEED_W = 13
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Converter samples
    input wire logic sample_valid_in,
    input wire aim_pkg::aim_samples_t samples_in,
    // Channel pull-up enables
    output logic [1:0] pullup_en_out,
    // Motor side
    output logic signed [12:0] speed_out,
    output logic motor_stop_out,
    output logic disc_error_out,
    output logic irq_out
);

    // Elaboration check: the speed path is built for 13 bits only
    if (SPEED_W != 13)
    begin : g_bad_width
        $error("SPEED_W must be 13");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [31:0] ctrl_q;                        // Control word
    logic seen_q;                               // A sample pair has arrived since reset
    aim_pkg::aim_cal_t cal1_q;                  // Throttle calibration
    aim_pkg::aim_cal_t cal2_q;                  // Steering calibration
    aim_pkg::aim_samples_t raw_q;               // Latest samples
    logic [aim_pkg::STAT_W-1:0] stat_q;         // Sticky events
    logic [aim_pkg::STAT_W-1:0] mask_q;         // Interrupt mask
    logic signed [12:0] speed_q;                // Speed command
    logic [1:0] sw_act_q;                       // Switch activity per channel
    logic [1:0] disc_q;                         // Disconnection per channel
    logic stop_q;                               // Motor stop

    // Bus data phase bookkeeping
    logic wr_pend_q;
    logic [7:0] addr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Field decode

    logic analog_mode;
    aim_pkg::aim_mix_t mix_mode;
    aim_pkg::aim_sw_t sw1_role;
    aim_pkg::aim_sw_t sw2_role;
    logic ign_disc;

    assign analog_mode = ctrl_q[aim_pkg::CTRL_ANALOG];
    assign mix_mode = aim_pkg::aim_mix_t'(ctrl_q[aim_pkg::CTRL_MIX_LO +: 2]);
    assign sw1_role = aim_pkg::aim_sw_t'(ctrl_q[aim_pkg::CTRL_SW1_LO +: 2]);
    assign sw2_role = aim_pkg::aim_sw_t'(ctrl_q[aim_pkg::CTRL_SW2_LO +: 2]);
    assign ign_disc = ctrl_q[aim_pkg::CTRL_IGN_DISC];
    assign pullup_en_out = ctrl_q[aim_pkg::CTRL_PULLUP2:aim_pkg::CTRL_PULLUP1];

    ////////////////////////////////////////////////////////////////////////////
    // Calibration function: raw sample to signed speed

    // Piecewise linear: neutral maps to zero, forward to full scale, the mirror
    // of forward about neutral to full reverse. A true divider keeps any
    // calibrated span exact, at the cost of area; a zero span gives zero speed.
    function automatic logic signed [12:0] calib(input logic [11:0] raw, input aim_pkg::aim_cal_t cal);
        logic signed [13:0] span;
        logic signed [13:0] off;
        logic signed [27:0] prod;
        logic signed [27:0] q;
        span = $signed({2'b00, cal.forward}) - $signed({2'b00, cal.neutral});
        off = $signed({2'b00, raw}) - $signed({2'b00, cal.neutral});
        prod = 28'(off) * 28'(aim_pkg::SPEED_MAX);
        if (span == 14'sd0)
            q = 28'sd0;
        else
            q = prod / 28'(span);
        if (q > 28'(aim_pkg::SPEED_MAX))
            calib = aim_pkg::SPEED_MAX;
        else if (q < -28'(aim_pkg::SPEED_MAX))
            calib = -aim_pkg::SPEED_MAX;
        else
            calib = q[12:0];
    endfunction : calib

    // Switch test shared by both channels
    function automatic logic sw_active(input logic [11:0] raw, input aim_pkg::aim_cal_t cal);
        logic signed [12:0] v;
        v = calib(raw, cal);
        sw_active = v > (aim_pkg::SPEED_MAX >>> 1);
    endfunction : sw_active

    ////////////////////////////////////////////////////////////////////////////
    // Combinational speed path

    logic signed [12:0] thr_cal;
    logic signed [12:0] str_cal;
    logic signed [13:0] mixed;
    logic signed [12:0] sat;
    logic [1:0] sw_now;
    logic [1:0] disc_now;
    logic kill;
    logic lim_fwd;
    logic lim_rev;

    assign thr_cal = calib(raw_q.ch1, cal1_q);
    assign str_cal = calib(raw_q.ch2, cal2_q);

    // Mixing mode selects the formula
    always_comb
    begin
        case (mix_mode)
            aim_pkg::AIM_MIX_LEFT: mixed = 14'(thr_cal) + 14'(str_cal);
            aim_pkg::AIM_MIX_RIGHT: mixed = 14'(thr_cal) - 14'(str_cal);
            default: mixed = 14'(thr_cal);
        endcase
    end

    // Clamp the sum or difference to the speed range
    always_comb
    begin
        if (mixed > 14'(aim_pkg::SPEED_MAX))
            sat = aim_pkg::SPEED_MAX;
        else if (mixed < -14'(aim_pkg::SPEED_MAX))
            sat = -aim_pkg::SPEED_MAX;
        else
            sat = mixed[12:0];
    end

    // Per-channel switch and disconnection detection
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chan
            logic [11:0] raw_g;
            aim_pkg::aim_cal_t cal_g;
            assign raw_g = (g == 0) ? raw_q.ch1 : raw_q.ch2;
            assign cal_g = (g == 0) ? cal1_q : cal2_q;
            // With the pull-up on, an open switch reads at the rail, which is
            // a valid inactive/active level, not a fault
            // Raw words read zero until the first sample, so no fault before it
            assign disc_now[g] = seen_q && !ign_disc && !pullup_en_out[g] &&
                                 (raw_g <= aim_pkg::DISC_LOW || raw_g >= aim_pkg::DISC_HIGH);
            assign sw_now[g] = sw_active(raw_g, cal_g);
        end
    endgenerate

    // Channel 1 only acts as switch when it is not driving speed
    logic ch1_free;
    logic ch2_free;
    assign ch1_free = !analog_mode;
    assign ch2_free = !analog_mode || (mix_mode == aim_pkg::AIM_MIX_OFF);
    always_comb
    begin
        kill = 1'b0;
        lim_fwd = 1'b0;
        lim_rev = 1'b0;
        if (ch1_free && sw_now[0])
        begin
            kill = sw1_role == aim_pkg::AIM_SW_KILL;
            lim_fwd = sw1_role == aim_pkg::AIM_SW_LIMIT_FWD;
            lim_rev = sw1_role == aim_pkg::AIM_SW_LIMIT_REV;
        end
        if (ch2_free && sw_now[1])
        begin
            kill = kill || (sw2_role == aim_pkg::AIM_SW_KILL);
            lim_fwd = lim_fwd || (sw2_role == aim_pkg::AIM_SW_LIMIT_FWD);
            lim_rev = lim_rev || (sw2_role == aim_pkg::AIM_SW_LIMIT_REV);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture

    // Samples are captured in every mode so software always sees them
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            raw_q <= '0;
            seen_q <= 1'b0;
        end
        else if (sample_valid_in)
        begin
            raw_q <= samples_in;
            seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Speed command and stop

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            speed_q <= '0;
            stop_q <= 1'b1;
            sw_act_q <= '0;
            disc_q <= '0;
        end
        else
        begin
            sw_act_q <= sw_now;
            disc_q <= disc_now;
            if (kill || (|disc_now) || !analog_mode)
            begin
                speed_q <= '0;
                stop_q <= 1'b1;
            end
            else if ((lim_fwd && sat > 13'sd0) || (lim_rev && sat < 13'sd0))
            begin
                speed_q <= '0;
                stop_q <= 1'b1;
            end
            else
            begin
                speed_q <= sat;
                stop_q <= 1'b0;
            end
        end
    end

    assign speed_out = speed_q;
    assign motor_stop_out = stop_q;
    assign disc_error_out = |disc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Events: bit0 new sample, bit1 disconnection, bit2 switch active, bit3 kill or limit active

    logic [aim_pkg::STAT_W-1:0] ev;
    assign ev = {kill || lim_fwd || lim_rev, |sw_now, |disc_now, sample_valid_in};

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    logic addr_ok;
    assign addr_ok = hsel_in && hready_in && htrans_in[1];

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_pend_q <= 1'b0;
            addr_q <= '0;
        end
        else if (hready_in)
        begin
            wr_pend_q <= addr_ok && hwrite_in;
            addr_q <= haddr_in[7:0];
        end
    end

    // Register writes in the data phase
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_q <= aim_pkg::CTRL_RST;
            cal1_q <= aim_pkg::aim_cal_t'({aim_pkg::CAL_RST[27:16], aim_pkg::CAL_RST[11:0]});
            cal2_q <= aim_pkg::aim_cal_t'({aim_pkg::CAL_RST[27:16], aim_pkg::CAL_RST[11:0]});
            mask_q <= aim_pkg::MASK_RST[aim_pkg::STAT_W-1:0];
        end
        else if (wr_pend_q)
        begin
            if (addr_q == aim_pkg::OFF_CTRL)
                ctrl_q <= {22'h0, hwdata_in[9:0]};
            else if (addr_q == aim_pkg::OFF_CAL1)
                cal1_q <= {hwdata_in[27:16], hwdata_in[11:0]};
            else if (addr_q == aim_pkg::OFF_CAL2)
                cal2_q <= {hwdata_in[27:16], hwdata_in[11:0]};
            else if (addr_q == aim_pkg::OFF_MASK)
                mask_q <= hwdata_in[aim_pkg::STAT_W-1:0];
        end
    end

    // Sticky status: a new event wins over a write-one clear
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            stat_q <= '0;
        else
        begin
            if (wr_pend_q && addr_q == aim_pkg::OFF_STAT)
                stat_q <= (stat_q & ~hwdata_in[aim_pkg::STAT_W-1:0]) | ev;
            else
                stat_q <= stat_q | ev;
        end
    end

    assign irq_out = |(stat_q & mask_q);

    // Read mux, unmapped addresses read zero
    always_comb
    begin
        if (addr_q == aim_pkg::OFF_CTRL)
            hrdata_out = ctrl_q;
        else if (addr_q == aim_pkg::OFF_CAL1)
            hrdata_out = {4'h0, cal1_q.forward, 4'h0, cal1_q.neutral};
        else if (addr_q == aim_pkg::OFF_CAL2)
            hrdata_out = {4'h0, cal2_q.forward, 4'h0, cal2_q.neutral};
        else if (addr_q == aim_pkg::OFF_RAW)
            hrdata_out = {4'h0, raw_q.ch2, 4'h0, raw_q.ch1};
        else if (addr_q == aim_pkg::OFF_SPEED)
            hrdata_out = {11'h0, disc_q, sw_act_q, stop_q, {{3{speed_q[12]}}, speed_q}};
        else if (addr_q == aim_pkg::OFF_STAT)
            hrdata_out = {28'h0, stat_q};
        else if (addr_q == aim_pkg::OFF_MASK)
            hrdata_out = {28'h0, mask_q};
        else
            hrdata_out = 32'h0000_0000;
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

endmodule : aim_speed_mixer

// *** aim_speed_mixer_monitor.sv ***
// Port checker for the analog input speed mixer
`timescale 1ns/100ps
module aim_speed_mixer_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Bus
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    // Converter and motor side
    input wire logic sample_valid_in,
    input wire logic [1:0] pullup_en_out,
    input wire logic signed [12:0] speed_out,
    input wire logic motor_stop_out,
    input wire logic disc_error_out,
    input wire logic irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////
    // History of samples and taken writes; outputs may only move shortly after one
    logic [2:0] v_hist_q;
    logic [2:0] w_hist_q;
    logic cause;
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            v_hist_q <= 3'h0;
            w_hist_q <= 3'h0;
        end
        else
        begin
            v_hist_q <= {v_hist_q[1:0], sample_valid_in};
            w_hist_q <= {w_hist_q[1:0], hsel_in & hready_in & htrans_in[1] & hwrite_in};
        end
    end
    assign cause = (|v_hist_q) | w_hist_q[1] | w_hist_q[2];
    ////////////////////////////////////////////////////////////////
    a_ready_high: assert property (hreadyout_out) else $error("hreadyout dropped");
    a_resp_okay: assert property (!hresp_out) else $error("response not okay");
    a_speed_range: assert property (speed_out <= 13'sh0c80 && speed_out >= -13'sh0c80)
        else $error("speed outside range");
    a_unmapped_zero: assert property (hsel_in && hready_in && htrans_in[1] && !hwrite_in
        && haddr_in[31:8] == 24'h0 && haddr_in[7:0] >= 8'h1c |=> hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_speed_cause: assert property ($changed(speed_out) |-> cause) else $error("speed moved alone");
    a_stop_cause: assert property ($changed(motor_stop_out) |-> cause) else $error("stop moved alone");
    a_disc_cause: assert property ($changed(disc_error_out) |-> cause) else $error("disc moved alone");
    a_irq_cause: assert property ($rose(irq_out) |-> cause) else $error("irq rose alone");
    a_pullup_write: assert property ($changed(pullup_en_out) |-> w_hist_q[1])
        else $error("pull-up moved without write");
endmodule : aim_speed_mixer_monitor
bind aim_speed_mixer aim_speed_mixer_monitor i_aim_speed_mixer_monitor (.clk_in, .nrst_in,
    .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .sample_valid_in, .pullup_en_out, .speed_out, .motor_stop_out, .disc_error_out, .irq_out);

// *** aim_pot_source.sv ***
// Model of two analog sources and their converter
`timescale 1ns/100ps
module aim_pot_source (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Wiper levels, broken wiring and pull-ups
    input wire logic [11:0] level1_in,
    input wire logic [11:0] level2_in,
    input wire logic [1:0] broken_in,
    input wire logic [1:0] pullup_en_in,
    // Converter output
    output logic sample_valid_out,
    output aim_pkg::aim_samples_t samples_out
);
    logic [1:0] tick_q; // One sample pair every four cycles
    // A broken wire floats: pulled high by the pull-up, else it sinks to the ground rail
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tick_q <= 2'h0;
            sample_valid_out <= 1'b0;
            samples_out <= 24'h0;
        end
        else
        begin
            tick_q <= tick_q + 2'h1;
            sample_valid_out <= (tick_q == 2'h3);
            samples_out.ch1 <= broken_in[0] ? (pullup_en_in[0] ? 12'hfff : 12'h000) : level1_in;
            samples_out.ch2 <= broken_in[1] ? (pullup_en_in[1] ? 12'hfff : 12'h000) : level2_in;
        end
    end
endmodule : aim_pot_source

// *** aim_speed_mixer_bench.sv ***
// Self-checking bench for the analog input speed mixer
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module aim_speed_mixer_bench;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [31:0] hwdata_in = 32'h0;
    logic [31:0] hrdata_out, r;
    logic hreadyout_out, hresp_out, sample_valid, motor_stop_out, disc_error_out, irq_out;
    aim_pkg::aim_samples_t samples;
    logic [1:0] pullup_en_out;
    logic signed [12:0] speed_out;
    logic [11:0] lv1 = 12'h800;
    logic [11:0] lv2 = 12'h800;
    logic [1:0] broken = 2'h0;
    int n_mismatch = 0;
    int total_checks = 0;
    localparam logic signed [12:0] MAX = aim_pkg::SPEED_MAX;
    always #4 clk_in = ~clk_in; // 125 MHz
    ////////////////////////////////////////////////////////////////
    aim_speed_mixer i_aim_speed_mixer (.clk_in(clk_in), .nrst_in(nrst_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
        .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .sample_valid_in(sample_valid),
        .samples_in(samples), .pullup_en_out(pullup_en_out), .speed_out(speed_out),
        .motor_stop_out(motor_stop_out), .disc_error_out(disc_error_out), .irq_out(irq_out));
    aim_pot_source i_aim_pot_source (.clk_in(clk_in), .nrst_in(nrst_in), .level1_in(lv1),
        .level2_in(lv2), .broken_in(broken), .pullup_en_in(pullup_en_out),
        .sample_valid_out(sample_valid), .samples_out(samples));
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // Bounded wait for hready at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (hreadyout_out !== 1'b1 && n < 50);
        if (hreadyout_out !== 1'b1)
        begin
            n_mismatch++;
            final_report();
        end
    endtask : wait_ready
    // One single-word transfer; read data taken at the data phase's closing edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= {24'h0, a};
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        wait_ready();
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_ready();
        r = hrdata_out;
    endtask : bus
    // Set levels and let three sample pairs pass
    task automatic apply(input logic [11:0] a, input logic [11:0] b);
        lv1 <= a;
        lv2 <= b;
        repeat (12) @(posedge clk_in);
    endtask : apply
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK(speed_out, 13'sh0000)
        `CHK(motor_stop_out, 1'b1)
        `CHK(pullup_en_out, 2'h0)
        `CHK(irq_out, 1'b0)
        bus(1'b0, aim_pkg::OFF_CAL2, 32'h0);
        `CHK(r, aim_pkg::CAL_RST)
        bus(1'b0, 8'h80, 32'h0);
        `CHK(r, 32'h0)
    endtask : t_reset
    // Three calibrated points; steering sweeps but must not matter
    task automatic t_direct;
        logic [11:0] lv [3] = '{12'hc00, 12'h800, 12'h400};
        logic signed [12:0] ex [3] = '{MAX, 13'sh0000, -MAX};
        bus(1'b1, aim_pkg::OFF_CAL1, 32'h0c00_0800);
        bus(1'b1, aim_pkg::OFF_CAL2, 32'h0c00_0800);
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            apply(lv[i], lv[2 - i]);
            `CHK(speed_out, ex[i])
            `CHK(motor_stop_out, 1'b0)
        end
    endtask : t_direct
    // Left sums and saturates, right subtracts
    task automatic t_mix;
        logic [31:0] c [5] = '{32'h3, 32'h3, 32'h3, 32'h5, 32'h5};
        logic [11:0] a [5] = '{12'hc00, 12'h800, 12'h400, 12'h800, 12'hc00};
        logic signed [12:0] ex [5] = '{MAX, MAX, 13'sh0000, -MAX, 13'sh0000};
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, aim_pkg::OFF_CTRL, c[i]);
            apply(a[i], 12'hc00);
            `CHK(speed_out, ex[i])
        end
    endtask : t_mix
    // Steering channel as kill, then as forward limit
    task automatic t_switch;
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h61);
        apply(12'hc00, 12'ha00);
        `CHK(motor_stop_out, 1'b0)
        apply(12'hc00, 12'ha10);
        `CHK(motor_stop_out, 1'b1)
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h21);
        apply(12'hc00, 12'ha10);
        `CHK(motor_stop_out, 1'b1)
        apply(12'h400, 12'hc00);
        `CHK(motor_stop_out, 1'b0)
        `CHK(speed_out, -MAX)
    endtask : t_switch
    // Disconnect, masking, ignore option and sticky clear
    task automatic t_disc;
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h61);
        bus(1'b1, aim_pkg::OFF_STAT, 32'hf);
        bus(1'b1, aim_pkg::OFF_MASK, 32'h2);
        apply(12'hc00, 12'h005);
        `CHK(disc_error_out, 1'b1)
        `CHK(irq_out, 1'b1)
        bus(1'b1, aim_pkg::OFF_MASK, 32'h0);
        @(posedge clk_in);
        `CHK(irq_out, 1'b0)
        bus(1'b1, aim_pkg::OFF_MASK, 32'h2);
        bus(1'b1, aim_pkg::OFF_CTRL, 32'he1);
        apply(12'hc00, 12'h005);
        `CHK(disc_error_out, 1'b0)
        `CHK(irq_out, 1'b1)
        bus(1'b1, aim_pkg::OFF_STAT, 32'h2);
        @(posedge clk_in);
        `CHK(irq_out, 1'b0)
    endtask : t_disc
    // Broken switch wire with and without the pull-up
    task automatic t_pull;
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h261);
        broken <= 2'h2;
        apply(12'hc00, 12'h800);
        `CHK(pullup_en_out, 2'h2)
        `CHK(disc_error_out, 1'b0)
        `CHK(motor_stop_out, 1'b1)
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h61);
        apply(12'hc00, 12'h800);
        `CHK(disc_error_out, 1'b1)
        broken <= 2'h0;
    endtask : t_pull
    // Samples readable outside analog mode
    task automatic t_raw;
        bus(1'b1, aim_pkg::OFF_CTRL, 32'h0);
        apply(12'h123, 12'h456);
        bus(1'b0, aim_pkg::OFF_RAW, 32'h0);
        `CHK(r, 32'h0456_0123)
        `CHK(speed_out, 13'sh0000)
        `CHK(motor_stop_out, 1'b1)
    endtask : t_raw
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_direct();
        t_mix();
        t_switch();
        t_disc();
        t_pull();
        t_raw();
        final_report();
    end
endmodule : aim_speed_mixer_bench
